// ### nps_buf_mem.sv
// 256 x 16 program buffer with registered read data
module nps_buf_mem (
  // clock
  input  wire logic        clk,
  // write port
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  // read port
  input  wire logic [7:0]  rd_addr,
  output logic      [15:0] rd_data
);
  logic [15:0] mem [0:255];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : nps_buf_mem

// ### nps_flash_model.sv
// behavioural nor flash at its pins: command decode, status reads, write log
module nps_flash_model (
  // flash pins
  input  wire logic [22:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] dq_wr,
  output logic      [15:0] dq_o,
  // fault shown when the next operation ends: 1 error, 2 buffer abort
  input  wire logic [1:0]  inj
);
  timeunit 1ns;
  timeprecision 1ps;
  import nps_pkg::*;
  logic [1:0]  st = 2'h0;        // 0 read, 1 busy, 2 failed, 3 aborted
  logic        saw80 = 1'b0;
  logic        in_ebp = 1'b0;
  logic        ebp_op = 1'b0;
  int          cnt = 0;
  int          left = 0;
  logic        tog = 1'b0;
  logic [15:0] last_w = 16'h0000;
  logic [15:0] arr = 16'h1234;
  logic [15:0] last_bus = 16'h0000;
  logic [15:0] rdv;
  logic [38:0] wlog[$];
  wire         pol = ebp_op ? last_w[7] : 1'b1;

  task automatic start(input logic [15:0] v);
    st = 2'h1;
    left = 2;
    saw80 = 1'b0;
    arr = v;
  endtask : start

  always_comb begin
    rdv = arr;
    if (st != 2'h0) begin
      rdv = 16'h0000;
      rdv[BIT_DATA_POLLING] = ~pol;
      rdv[BIT_TOGGLE] = tog;
      rdv[BIT_ERROR] = (st == 2'h2);
      rdv[BIT_BUFFER_ABORT] = (st == 2'h3);
    end
  end
  // released bus shows the inverse of its last value, never a held copy
  assign dq_o = oe_n ? ~last_bus : rdv;

  always @(posedge oe_n) begin
    last_bus = rdv;
    tog = ~tog;
    if (st == 2'h1) begin
      left--;
      if (left == 0) st = (inj == 2'h1) ? 2'h2 : (inj == 2'h2) ? 2'h3 : 2'h0;
    end
  end

  always @(posedge we_n) begin
    if (!ce_n) wlog.push_back({addr, dq_wr});
    if (!ce_n && st != 2'h1) begin
      if (in_ebp) begin
        cnt++;
        if (cnt > 256 || addr[7:0] != 8'(cnt - 1)) begin
          in_ebp = 1'b0;
          ebp_op = 1'b1;
          if (cnt > 256 && dq_wr == CMD_EBP_CONFIRM) start(last_w);
          else st = 2'h3;
        end else begin
          last_w = dq_wr;
        end
      end else if (dq_wr == CMD_RESET) begin
        st = 2'h0;
      end else if (dq_wr == CMD_EBP_SETUP) begin
        in_ebp = 1'b1;
        cnt = 0;
      end else if (dq_wr == CMD_ERASE_SETUP) begin
        saw80 = 1'b1;
      end else if (saw80 && (dq_wr == CMD_CHIP || dq_wr == CMD_BLOCK)) begin
        ebp_op = 1'b0;
        start(16'hFFFF);
      end
    end
  end
endmodule : nps_flash_model

// ### nps_pkg.sv
// shared constants and types of the nor program/erase host sequencer
package nps_pkg;

  // clock and bus timing, printed figures in ns; synchroniser depth in stages
  localparam int CLK_NS        = 10;
  localparam int T_AS_NS       = 10;
  localparam int T_WP_NS       = 45;
  localparam int T_WPH_NS      = 30;
  localparam int T_ACC_NS      = 80;
  localparam int SYNC_STAGES   = 3;
  // least times round up to whole cycles
  localparam logic [4:0] CYC_AS  = 5'((T_AS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] CYC_WP  = 5'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] CYC_WPH = 5'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] CYC_RD  = 5'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);

  // flash geometry
  localparam int          ADDR_W    = 23;
  localparam int          DATA_W    = 16;
  localparam logic [8:0]  BUF_WORDS = 9'h100;

  // flash command cycles (word mode)
  localparam logic [22:0] ADR_UNLOCK1     = 23'h000555;
  localparam logic [22:0] ADR_UNLOCK2     = 23'h0002AA;
  localparam logic [15:0] CMD_UNLOCK1     = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2     = 16'h0055;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_CHIP        = 16'h0010;
  localparam logic [15:0] CMD_BLOCK       = 16'h0030;
  localparam logic [15:0] CMD_RESUME      = 16'h0030;
  localparam logic [15:0] CMD_SUSPEND     = 16'h00B0;
  localparam logic [15:0] CMD_RESET       = 16'h00F0;
  localparam logic [15:0] CMD_EBP_SETUP   = 16'h0033;
  localparam logic [15:0] CMD_EBP_CONFIRM = 16'h0029;

  // status bit positions in a flash status read
  localparam int BIT_DATA_POLLING = 7;
  localparam int BIT_TOGGLE       = 6;
  localparam int BIT_ERROR        = 5;
  localparam int BIT_BUFFER_ABORT = 1;

  // own register map
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_BUF    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BYPASS = 4;
  localparam int CTRL_EXPECT = 5;
  localparam int STS_BUSY    = 0;
  localparam int STS_DONE    = 1;
  localparam int STS_FAIL    = 2;
  localparam int STS_ABORTED = 3;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_SUSPEND, OP_RESUME, OP_EBP, OP_CHIP,
    OP_BLOCK, OP_BLOCK_ADD, OP_RESET, OP_ABORT, OP_POLL
  } nps_op_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } nps_apb_req_t;

  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        byte_n;
  } nps_flash_out_t;

endpackage : nps_pkg

// ### nps_sequencer.sv
// host sequencer driving a parallel nor flash, apb register front end
// Functional notes
// R1 - device accepts program suspend during program inside erase suspension
// R2 - device serves auto-select reads while program-suspended, then returns there
// R3 - host writes 30h to resume; program continues, tracked by status bits
// R4 - device ignores repeated resumes; new suspend allowed after restart
// R5 - enhanced buffered program: x16 only, 256 words sharing A22-A8
// R6 - host order: two unlocks, setup to block, 256 loads, confirm
// R7 - host loads words consecutively, low address byte 00h up to FFh
// R8 - device aborts buffered program on bad address or sequence
// R9 - device reports buffer-abort, error, toggle and data-polling bits
// R10 - bypass form drops the two unlocks, otherwise identical, confirm programs 256
// R11 - error bit: host issues reset; buffer-abort bit: host issues abort-reset
// R12 - after error bit host re-checks data-polling bit before failing
// R13 - chip erase is six writes with codes 80h then 10h
// R14 - device skips protected blocks in chip erase without error
// R15 - device ignores all commands during chip erase, reads return status
// R16 - erase success returns to read mode; error needs read/reset
// R17 - bypass chip erase needs only two writes
// R18 - block erase six writes 80h then 30h; extra blocks repeat sixth write
// R19 - device restarts selection timeout per added block, closes at start
// R20 - device returns status from sixth block erase write onward
// R21 - device skips protected blocks in block erase without error
// R22 - during block erase only suspend and early read/reset are honoured
// R23 - host writes F0h abort-reset; device leaves aborted buffer program
// R24 - device decodes sequences from successive writes, unknown means nothing
module nps_sequencer (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // apb slave
  input  wire nps_pkg::nps_apb_req_t   apb_req,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // flash pins
  output nps_pkg::nps_flash_out_t      flash_out,
  input  wire logic [15:0]             flash_dq_in
);
  import nps_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PREP, ST_ADDR, ST_WE_LOW, ST_WE_HIGH, ST_LAUNCH, ST_RD, ST_EVAL
  } nps_state_t;

  nps_state_t  state;
  nps_op_t     op;
  logic        byp;
  logic [8:0]  step;
  logic [4:0]  tmr;
  logic [15:0] rd_word;
  logic        recheck;
  logic        expect_bit;
  logic        sts_done;
  logic        sts_fail;
  logic        sts_aborted;
  logic [3:0]  ctrl_op;
  logic        ctrl_byp;
  logic        ctrl_exp;
  logic [22:0] addr_reg;
  logic [8:0]  fill;
  logic        start;
  logic [15:0] sync1;
  logic [15:0] sync2;
  logic [15:0] sync3;
  logic [15:0] mem_rdata;

  // apb decode
  wire logic access   = apb_req.psel & apb_req.penable & ~pready;
  wire logic wr_fire  = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
  wire logic hit_ctrl = apb_req.paddr == OFS_CTRL;
  wire logic hit_addr = apb_req.paddr == OFS_ADDR;
  wire logic hit_buf  = apb_req.paddr == OFS_BUF;
  wire logic hit_sts  = apb_req.paddr == OFS_STATUS;
  wire logic hit_rd   = apb_req.paddr == OFS_RDATA;
  wire logic hit      = hit_ctrl | hit_addr | hit_buf | hit_sts | hit_rd;
  wire logic busy     = (state != ST_IDLE) | start;
  wire logic [3:0] wr_op   = apb_req.pwdata[CTRL_OP_LSB +: 4];
  wire logic op_known      = wr_op <= 4'(OP_POLL);
  // buffered program only starts on a full buffer, so loads are always 00h..FFh
  wire logic ebp_ready     = fill == BUF_WORDS; // R7
  wire logic start_ok      = wr_fire & hit_ctrl & ~busy & op_known
                           & ((wr_op != 4'(OP_EBP)) | ebp_ready);
  wire logic buf_push      = wr_fire & hit_buf & (fill != BUF_WORDS);
  wire logic [3:0] sts_clr = (wr_fire & hit_sts) ? apb_req.pwdata[3:0] : 4'h0;
  wire logic [31:0] sts_word = {28'h0000000, sts_aborted, sts_fail, sts_done, busy};
  wire logic [31:0] rd_mux =
      hit_ctrl ? {26'h0000000, ctrl_exp, ctrl_byp, ctrl_op} :
      hit_addr ? {9'h000, addr_reg} :
      hit_buf  ? {23'h000000, fill} :
      hit_sts  ? sts_word :
      hit_rd   ? {16'h0000, rd_word} : RST_WORD;

  // step table: es is the step index of the full unlocked form
  logic [8:0]  es;
  logic [22:0] st_addr;
  logic [15:0] st_data;
  logic        last_step;
  wire logic [22:0] blk_base = {addr_reg[22:8], 8'h00};
  wire logic [22:0] ebp_last = {addr_reg[22:8], 8'hFF};
  wire logic        is_erase = (op == OP_CHIP) | (op == OP_BLOCK);
  wire logic        needs_poll = is_erase | (op == OP_EBP);

  always_comb begin
    es        = step;
    st_addr   = addr_reg;
    st_data   = CMD_RESET;
    last_step = 1'b1;
    case (op)
      OP_CHIP, OP_BLOCK: begin
        if (byp) begin
          es = (step == 9'h000) ? 9'h002 : 9'h005; // R17
        end
        last_step = es == 9'h005; // R13 R18
        case (es)
          9'h000, 9'h003: begin st_addr = ADR_UNLOCK1; st_data = CMD_UNLOCK1; end
          9'h001, 9'h004: begin st_addr = ADR_UNLOCK2; st_data = CMD_UNLOCK2; end
          9'h002: begin st_addr = ADR_UNLOCK1; st_data = CMD_ERASE_SETUP; end
          default: begin
            st_addr = (op == OP_CHIP) ? ADR_UNLOCK1 : addr_reg;
            st_data = (op == OP_CHIP) ? CMD_CHIP : CMD_BLOCK;
          end
        endcase
      end
      OP_BLOCK_ADD: begin
        st_data = CMD_BLOCK; // R18
      end
      OP_EBP: begin
        es        = byp ? 9'(step + 9'h002) : step; // R10
        last_step = es == 9'h103;
        case (es)
          9'h000: begin st_addr = ADR_UNLOCK1; st_data = CMD_UNLOCK1; end
          9'h001: begin st_addr = ADR_UNLOCK2; st_data = CMD_UNLOCK2; end
          9'h002: begin st_addr = blk_base; st_data = CMD_EBP_SETUP; end // R6
          9'h103: begin st_addr = blk_base; st_data = CMD_EBP_CONFIRM; end
          default: begin
            st_addr = {addr_reg[22:8], 8'(es - 9'h003)}; // R5 R7
            st_data = mem_rdata;
          end
        endcase
      end
      OP_ABORT: begin
        // full three-cycle form, also in bypass mode
        last_step = step == 9'h002; // R23
        case (step)
          9'h000: begin st_addr = ADR_UNLOCK1; st_data = CMD_UNLOCK1; end
          9'h001: begin st_addr = ADR_UNLOCK2; st_data = CMD_UNLOCK2; end
          default: begin st_addr = ADR_UNLOCK1; st_data = CMD_RESET; end
        endcase
      end
      OP_SUSPEND: st_data = CMD_SUSPEND;
      OP_RESUME:  st_data = CMD_RESUME; // R3
      default:    st_data = CMD_RESET;
    endcase
  end

  // poll decision on the captured status word
  wire logic dp_ok    = rd_word[BIT_DATA_POLLING] == expect_bit;
  wire logic err_seen = rd_word[BIT_ERROR];
  wire logic abt_seen = rd_word[BIT_BUFFER_ABORT] & (op == OP_EBP);
  wire logic rd_agree = sync2 == sync3;
  wire logic tmr_end  = tmr == 5'h01;

  nps_buf_mem u_buf (
    .clk     (clk),
    .wr_en   (buf_push),
    .wr_addr (fill[7:0]),
    .wr_data (apb_req.pwdata[15:0]),
    .rd_addr (8'(es - 9'h003)),
    .rd_data (mem_rdata)
  );

  // apb side registers; one wait state, then pready with data
  always_ff @(posedge clk) begin
    if (reset) begin
      pready   <= 1'b0;
      prdata   <= RST_WORD;
      pslverr  <= 1'b0;
      ctrl_op  <= 4'h0;
      ctrl_byp <= 1'b0;
      ctrl_exp <= 1'b1;
      addr_reg <= 23'h000000;
      fill     <= 9'h000;
      start    <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access & ~hit;
      if (access) begin
        prdata <= rd_mux;
      end
      if (wr_fire & hit_addr) begin
        addr_reg <= apb_req.pwdata[22:0];
      end
      if (start_ok) begin
        ctrl_op  <= wr_op;
        ctrl_byp <= apb_req.pwdata[CTRL_BYPASS];
        ctrl_exp <= apb_req.pwdata[CTRL_EXPECT];
      end
      start <= start_ok;
      // buffer is spent once a buffered program is launched
      if (start_ok & (wr_op == 4'(OP_EBP))) begin
        fill <= 9'h000;
      end else if (buf_push) begin
        fill <= 9'(fill + 9'h001);
      end
    end
  end

  // three-stage pin synchroniser for read data
  always_ff @(posedge clk) begin
    sync1 <= flash_dq_in;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= ST_IDLE;
      op          <= OP_NONE;
      byp         <= 1'b0;
      step        <= 9'h000;
      tmr         <= 5'h01;
      rd_word     <= 16'h0000;
      recheck     <= 1'b0;
      expect_bit  <= 1'b1;
      sts_done    <= 1'b0;
      sts_fail    <= 1'b0;
      sts_aborted <= 1'b0;
      flash_out   <= '{addr: 23'h000000, dq_out: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1,
                       oe_n: 1'b1, we_n: 1'b1, byte_n: 1'b1};
    end else begin
      // software clears; a set in the same cycle below wins
      sts_done    <= sts_done & ~sts_clr[STS_DONE];
      sts_fail    <= sts_fail & ~sts_clr[STS_FAIL];
      sts_aborted <= sts_aborted & ~sts_clr[STS_ABORTED];
      flash_out.byte_n <= 1'b1; // R5
      case (state)
        ST_IDLE: begin
          if (start) begin
            op         <= nps_op_t'(ctrl_op);
            byp        <= ctrl_byp;
            step       <= 9'h000;
            recheck    <= 1'b0;
            expect_bit <= is_erase ? 1'b1 : ctrl_exp; // R16
            if (ctrl_op == 4'(OP_NONE)) begin
              sts_done <= 1'b1;
            end else if (ctrl_op == 4'(OP_READ) || ctrl_op == 4'(OP_POLL)) begin
              state <= ST_LAUNCH;
            end else begin
              state <= ST_PREP;
            end
          end
          if (start && (ctrl_op == 4'(OP_CHIP) || ctrl_op == 4'(OP_BLOCK))) begin
            expect_bit <= 1'b1;
          end
        end
        ST_PREP: begin
          // one cycle lets the buffer read data settle
          tmr   <= CYC_AS;
          state <= ST_ADDR;
        end
        ST_ADDR: begin
          flash_out.addr   <= st_addr;
          flash_out.dq_out <= st_data;
          flash_out.dq_oe  <= 1'b1;
          flash_out.ce_n   <= 1'b0;
          if (op == OP_EBP && es == 9'h102) begin
            expect_bit <= mem_rdata[BIT_DATA_POLLING];
          end
          // strobe waits for ce_n low, so the address is set up before it falls
          if (tmr_end && !flash_out.ce_n) begin
            flash_out.we_n <= 1'b0;
            tmr            <= CYC_WP;
            state          <= ST_WE_LOW;
          end else if (!flash_out.ce_n) begin
            tmr <= 5'(tmr - 5'h01);
          end
        end
        ST_WE_LOW: begin
          if (tmr_end) begin
            flash_out.we_n <= 1'b1;
            tmr            <= CYC_WPH;
            state          <= ST_WE_HIGH;
          end else begin
            tmr <= 5'(tmr - 5'h01);
          end
        end
        ST_WE_HIGH: begin
          if (tmr_end) begin
            flash_out.ce_n  <= 1'b1;
            flash_out.dq_oe <= 1'b0;
            if (!last_step) begin
              step  <= 9'(step + 9'h001); // R6
              state <= ST_PREP;
            end else if (needs_poll) begin
              state <= ST_LAUNCH;
            end else begin
              sts_done <= 1'b1;
              state    <= ST_IDLE;
            end
          end else begin
            tmr <= 5'(tmr - 5'h01);
          end
        end
        ST_LAUNCH: begin
          flash_out.addr  <= (op == OP_EBP) ? ebp_last : addr_reg;
          flash_out.dq_oe <= 1'b0;
          flash_out.ce_n  <= 1'b0;
          flash_out.oe_n  <= 1'b0;
          tmr             <= CYC_RD;
          state           <= ST_RD;
        end
        ST_RD: begin
          if (!tmr_end) begin
            tmr <= 5'(tmr - 5'h01);
          end else if (rd_agree) begin
            rd_word        <= sync3;
            flash_out.ce_n <= 1'b1;
            flash_out.oe_n <= 1'b1;
            state          <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          if (op == OP_READ || dp_ok) begin
            sts_done <= 1'b1;
            state    <= ST_IDLE;
          end else if (recheck) begin
            sts_fail <= 1'b1; // R11 R12
            op       <= OP_RESET;
            step     <= 9'h000;
            state    <= ST_PREP;
          end else if (err_seen) begin
            recheck <= 1'b1; // R12
            state   <= ST_LAUNCH;
          end else if (abt_seen) begin
            sts_aborted <= 1'b1; // R11
            op          <= OP_ABORT;
            step        <= 9'h000;
            state       <= ST_PREP;
          end else begin
            state <= ST_LAUNCH;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : nps_sequencer

// ### nps_sequencer_asserts.sv
// port checker of the nor program/erase host sequencer, with its bind
module nps_sequencer_asserts (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    reset,
  // apb slave side
  input wire nps_pkg::nps_apb_req_t   apb_req,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  // flash pins
  input wire nps_pkg::nps_flash_out_t flash_out,
  input wire logic [15:0]             flash_dq_in
);
  import nps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire wr_low = !flash_out.we_n;
  wire rd_low = !flash_out.oe_n;

  AST_APB_ANSWER: assert property (apb_req.psel && $rose(apb_req.penable) |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");
  AST_ERR_READY: assert property (pslverr |-> pready && (apb_req.pwrite || prdata == 32'h0))
    else $error("slave error without ready or with data");
  AST_WE_PULSE: assert property ($fell(flash_out.we_n) |-> wr_low [*5] ##1 !wr_low)
    else $error("write pulse not five cycles");
  AST_WE_RECOVER: assert property ($rose(flash_out.we_n) |-> !wr_low [*3])
    else $error("write recovery under three cycles");
  AST_HOLD: assert property (wr_low |-> $stable(flash_out.addr) && $stable(flash_out.dq_out))
    else $error("address or data moved in write pulse");
  AST_WRITE_BUS: assert property (wr_low |-> flash_out.dq_oe && !flash_out.ce_n && !rd_low)
    else $error("write pulse without driven bus");
  AST_READ_BUS: assert property (rd_low |-> !flash_out.dq_oe && !flash_out.ce_n)
    else $error("read while host drives the bus");
  AST_READ_LEN: assert property ($fell(flash_out.oe_n) |-> rd_low [*8])
    else $error("status read shorter than access time");
  AST_X16: assert property (flash_out.byte_n)
    else $error("flash left word mode");
  COV_CHIP: cover property ($fell(flash_out.we_n) && flash_out.dq_out == CMD_CHIP);
  COV_RESET: cover property ($fell(flash_out.we_n) && flash_out.dq_out == CMD_RESET);
  COV_ERR: cover property (pslverr);
endmodule : nps_sequencer_asserts

bind nps_sequencer nps_sequencer_asserts u_chk (.clk(clk), .reset(reset), .apb_req(apb_req),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .flash_out(flash_out),
  .flash_dq_in(flash_dq_in));

// ### nps_sequencer_tb.sv
// self-checking bench of the nor program/erase host sequencer
module nps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nps_pkg::*;
  logic           clk = 1'b0;
  logic           reset = 1'b1;
  nps_apb_req_t   req = '0;
  logic           pready;
  logic [31:0]    prdata;
  logic           pslverr;
  nps_flash_out_t fo;
  logic [15:0]    dq_o;
  logic [1:0]     inj = 2'h0;
  wire  [15:0]    dq_in = fo.dq_oe ? fo.dq_out : dq_o;
  int             n_fail = 0;
  int             samples_checked = 0;
  int             cyc = 0;
  int             wi = 0;
  logic [31:0]    lfsr = 32'h01826194;
  logic [31:0]    rd;
  logic           rerr;
  logic [39:0]    exq[$];
  logic [22:0]    blk = 23'h3C4500;

  nps_sequencer uut (.clk(clk), .reset(reset), .apb_req(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .flash_out(fo), .flash_dq_in(dq_in));
  nps_flash_model fm (.addr(fo.addr), .ce_n(fo.ce_n), .oe_n(fo.oe_n), .we_n(fo.we_n),
    .dq_wr(fo.dq_out), .dq_o(dq_o), .inj(inj));

  initial begin
    forever #5 clk = ~clk;
  end
  // whole run needs about 9000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      stop_test();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [31:0] sts_of(input logic fail, input logic abrt);
    return (32'(abrt) << STS_ABORTED) | (32'(fail) << STS_FAIL) | (32'h1 << STS_DONE);
  endfunction : sts_of

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; an idle edge follows so the next setup never collides
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic ex(input logic [22:0] a, input logic [15:0] d, input logic ca);
    exq.push_back({ca, a, d});
  endtask : ex
  task automatic unl();
    ex(ADR_UNLOCK1, CMD_UNLOCK1, 1'b1);
    ex(ADR_UNLOCK2, CMD_UNLOCK2, 1'b1);
  endtask : unl
  task automatic op(input nps_op_t c, input logic byp, input logic [22:0] a,
                    input logic f, input logic ab);
    int t;
    t = 0;
    apb(1'b1, OFS_ADDR, 32'(a));
    apb(1'b1, OFS_CTRL, 32'(c) | (32'(byp) << CTRL_BYPASS));
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      t++;
    end while (rd[STS_BUSY] !== 1'b0 && t < 3000);
    chk(rd, sts_of(f, ab));
    apb(1'b1, OFS_STATUS, 32'h0000000E);
  endtask : op
  // cycles queued without an address flag (bypass chip erase, suspend, resume, reset) have only their data compared
  task automatic chk_log();
    foreach (exq[i]) begin
      if (exq[i][39]) chk(32'(fm.wlog[wi][38:16]), 32'(exq[i][38:16]));
      chk(32'(fm.wlog[wi][15:0]), 32'(exq[i][15:0]));
      wi++;
    end
    chk(32'(fm.wlog.size()), 32'(wi));
    exq.delete();
  endtask : chk_log

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, RST_WORD);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[31:1], rerr}, 32'h00000001);
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      inj <= (k == 2) ? 2'h1 : 2'h0;
      if (k != 1) unl();
      ex(ADR_UNLOCK1, CMD_ERASE_SETUP, k != 1);
      if (k != 1) unl();
      ex(ADR_UNLOCK1, CMD_CHIP, k != 1);
      if (k == 2) ex(ADR_UNLOCK1, CMD_RESET, 1'b0);
      op(OP_CHIP, k == 1, 23'h0, k == 2, 1'b0);
      chk_log();
    end
    inj <= 2'h0;
    op(OP_READ, 1'b0, 23'h0, 1'b0, 1'b0);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(rd, 32'h0000FFFF);
    $display("test chip erase done");
    unl();
    ex(ADR_UNLOCK1, CMD_ERASE_SETUP, 1'b1);
    unl();
    ex(23'h1A0000, CMD_BLOCK, 1'b1);
    op(OP_BLOCK, 1'b0, 23'h1A0000, 1'b0, 1'b0);
    ex(23'h2B0000, CMD_BLOCK, 1'b1);
    op(OP_BLOCK_ADD, 1'b0, 23'h2B0000, 1'b0, 1'b0);
    ex(23'h0, CMD_SUSPEND, 1'b0);
    op(OP_SUSPEND, 1'b0, 23'h2B0000, 1'b0, 1'b0);
    ex(23'h0, CMD_RESUME, 1'b0);
    op(OP_RESUME, 1'b0, 23'h2B0000, 1'b0, 1'b0);
    ex(23'h0, CMD_RESET, 1'b0);
    op(OP_RESET, 1'b0, 23'h2B0000, 1'b0, 1'b0);
    op(OP_NONE, 1'b0, 23'h0, 1'b0, 1'b0);
    chk_log();
    $display("test block erase done");
    for (int k = 0; k < 2; k++) begin
      inj <= (k == 0) ? 2'h2 : 2'h0;
      if (k == 0) unl();
      ex(blk, CMD_EBP_SETUP, 1'b1);
      for (int i = 0; i < 257; i++) begin
        lfsr = nxt(lfsr);
        apb(1'b1, OFS_BUF, {16'h0000, lfsr[15:0]});
        if (i < 256) ex({blk[22:8], 8'(i)}, lfsr[15:0], 1'b1);
      end
      apb(1'b0, OFS_BUF, 32'h0);
      chk(rd, 32'h00000100);
      ex(blk, CMD_EBP_CONFIRM, 1'b1);
      if (k == 0) unl();
      if (k == 0) ex(ADR_UNLOCK1, CMD_RESET, 1'b1);
      op(OP_EBP, k == 1, blk, 1'b0, k == 0);
      chk_log();
    end
    $display("test buffered program done");
    stop_test();
  end
endmodule : nps_sequencer_tb
